// File: src/spi_status_readback.sv
// serial status readback: pin sampling, shift path, readback select
`include "spi_readback_defines.svh"

module spi_status_readback
   import spi_readback_pkg::*;
#(
   // identification pattern, value arbitrary
   parameter field_t PRODUCT_IDENT = 9'h0A4
)
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   // serial link pins
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              si,
   output logic                   so_out,
   output logic                   so_oe,
   // per-output fault sources
   input  wire logic [`OUT_N-1:0] overcurrent_flag,
   input  wire logic [`OUT_N-1:0] severe_short_flag,
   input  wire logic [`OUT_N-1:0] overtemperature_flag,
   input  wire logic [`OUT_N-1:0] short_to_supply_flag,
   input  wire logic [`OUT_N-1:0] open_load_off_flag,
   input  wire logic [`OUT_N-1:0] open_load_on_flag,
   // global status sources
   input  wire logic              undervoltage_flag,
   input  wire logic              overvoltage_flag,
   input  wire logic              por_event,
   input  wire logic              normal_operation_flag,
   // diagnostic sources
   input  wire logic              clock_fail,
   input  wire logic              cal_fail,
   input  wire logic              thermal_prewarning,
   input  wire logic              watchdog_active,
   input  wire logic [`OUT_N-1:0] direct_in,
   // state shown to the rest of the device
   output logic [`SEL_W-1:0]      readback_select_bits,
   output logic                   watchdog_toggle_echo,
   output field_t                 global_config_register
);

   //---------------------------------------------------------
   // pin synchronisers
   //---------------------------------------------------------
   logic [`SYNC_W-1:0] pin_raw;
   logic [`SYNC_W-1:0] sync1_q;
   logic [`SYNC_W-1:0] sync2_q;
   logic [1:0]         edge_q;
   logic               sclk_s;
   logic               cs_s;
   logic               si_s;
   logic [`OUT_N-1:0]  in_s;
   logic               sclk_rise;
   logic               sclk_fall;
   logic               cs_fall;
   logic               cs_rise;

   assign pin_raw = {direct_in, si, cs_n, sclk};

   // two stages, then one more for edge finding
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1_q <= `SYNC_RESET;
         sync2_q <= `SYNC_RESET;
         edge_q  <= `EDGE_RESET;
      end
      else
      begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         edge_q  <= sync2_q[1:0];
      end
   end

   // edges seen only after the second stage
   assign sclk_s    = sync2_q[0];
   assign cs_s      = sync2_q[1];
   assign si_s      = sync2_q[2];
   assign in_s      = sync2_q[`SYNC_W-1:3];
   assign sclk_rise = sclk_s & ~edge_q[0];
   assign sclk_fall = ~sclk_s & edge_q[0];
   assign cs_fall   = ~cs_s & edge_q[1];
   assign cs_rise   = cs_s & ~edge_q[1];

   //---------------------------------------------------------
   // link state and shift path
   //---------------------------------------------------------
   link_state_t       state_q;
   link_state_t       state_d;
   logic [`CNT_W-1:0] cnt_q;
   logic [`CNT_W-1:0] cnt_d;
   logic              got_q;
   logic              got_d;
   word_t             rx_q;
   word_t             rx_d;
   word_t             shreg_q;
   word_t             shreg_d;
   word_t             tx_word;
   logic              len_ok;
   logic              commit;

   // frame length check on chip select rising
   assign len_ok = got_q && (cnt_q == `CNT_ZERO); // [RULE5]
   assign commit = (state_q == LINK_FRAME) && cs_rise && len_ok;

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      got_d   = got_q;
      rx_d    = rx_q;
      shreg_d = shreg_q;
      case (state_q)
         LINK_IDLE:
         begin
            if (cs_fall)
            begin
               state_d = LINK_FRAME;
               cnt_d   = `CNT_ZERO;
               got_d   = 1'b0;
               shreg_d = tx_word; // [RULE1] [RULE3]
            end
         end
         LINK_FRAME:
         begin
            if (cs_rise)
               state_d = LINK_IDLE;
            if (sclk_rise && !cs_rise)
            begin
               rx_d  = {rx_q[`WORD_W-2:0], si_s};
               cnt_d = cnt_q + `CNT_ONE;
               got_d = 1'b1;
            end
            // msb leaves first, received bits follow
            if (sclk_fall && !cs_rise)
               shreg_d = {shreg_q[`WORD_W-2:0], rx_q[0]}; // [RULE2] [RULE4]
         end
         default: state_d = LINK_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= LINK_IDLE;
         cnt_q   <= `CNT_ZERO;
         got_q   <= 1'b0;
         rx_q    <= '0;
         shreg_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         got_q   <= got_d;
         rx_q    <= rx_d;
         shreg_q <= shreg_d;
      end
   end

   // output floats outside a frame
   assign so_out = shreg_q[`WORD_W-1];
   assign so_oe  = (state_q == LINK_FRAME); // [RULE6]

   //---------------------------------------------------------
   // command decode and readback state
   //---------------------------------------------------------
   logic [2:0]        cmd_addr;
   logic [1:0]        cmd_out;
   logic [2:0]        wr_kind;
   logic [2:0]        rd_kind;
   logic [1:0]        out_i;
   logic [2:0]        sel_kind;
   logic [`SEL_W-1:0] sel_q;
   logic [`SEL_W-1:0] sel_d;
   logic              wd_q;
   logic              wd_d;
   field_t            gcr_q;
   field_t            gcr_d;
   logic              por_q;
   logic              por_d;
   logic              load_fault_q;
   logic              load_fault_d;
   logic [`FLT_W-1:0] acc_q;
   logic [`FLT_W-1:0] acc_d;
   logic [`FLT_W-1:0] fault_live;
   logic              mem_wr;
   field_t            rd_data;
   field_t            low;

   assign cmd_addr = rx_q[`CMD_ADDR_HI:`CMD_ADDR_LO];
   assign cmd_out  = rx_q[`CMD_OUT_HI:`CMD_OUT_LO];
   assign wr_kind  = cmd_addr - `ADDR_DUTY;
   assign out_i    = sel_q[`SEL_W-1:`SEL_W-2]; // [RULE8]
   assign sel_kind = sel_q[2:0];
   assign rd_kind  = sel_kind - `ADDR_DUTY;
   assign fault_live = {undervoltage_flag, overvoltage_flag,
                        open_load_on_flag, open_load_off_flag,
                        short_to_supply_flag, overtemperature_flag,
                        severe_short_flag, overcurrent_flag};
   assign mem_wr = commit && (cmd_addr >= `ADDR_DUTY)
                   && (cmd_addr <= `ADDR_OCR);

   always_comb
   begin
      sel_d        = sel_q;
      wd_d         = wd_q;
      gcr_d        = gcr_q;
      por_d        = por_q;
      acc_d        = acc_q;
      load_fault_d = load_fault_q;
      // faults gather between frames, frozen inside one
      if (state_q == LINK_IDLE)
      begin
         acc_d = acc_q | fault_live; // [RULE10]
         if (cs_fall)
            load_fault_d = (sel_kind == `ADDR_STATUS);
      end
      // only a good frame stores and restarts fault capture
      if (commit)
      begin
         acc_d = fault_live;    // [RULE6] [RULE11]
         wd_d  = rx_q[`CMD_WD]; // [RULE12]
         if (cmd_addr == `ADDR_STATUS)
            sel_d = rx_q[`CMD_SEL_HI:`CMD_SEL_LO]; // [RULE9]
         if ((cmd_addr == `ADDR_GCR) && (cmd_out == `OUT_GLOBAL))
            gcr_d = rx_q[`DATA_W-1:0];
         if (load_fault_q)
            por_d = 1'b0; // [RULE18]
      end
      // a new power-on event beats the clearing read
      if (por_event)
         por_d = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sel_q        <= '0;
         wd_q         <= 1'b0;
         gcr_q        <= '0;
         por_q        <= `POR_RESET;
         load_fault_q <= 1'b0;
         acc_q        <= '0;
      end
      else
      begin
         sel_q        <= sel_d;
         wd_q         <= wd_d;
         gcr_q        <= gcr_d;
         por_q        <= por_d;
         load_fault_q <= load_fault_d;
         acc_q        <= acc_d;
      end
   end

   cfg_store cfg_store_inst
   (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .wr_en   (mem_wr),
      .wr_addr ({cmd_out, wr_kind[1:0]}),
      .wr_data (rx_q[`DATA_W-1:0]),
      .rd_addr ({out_i, rd_kind[1:0]}),
      .rd_data (rd_data)
   );

   //---------------------------------------------------------
   // returned word assembly
   //---------------------------------------------------------
   always_comb
   begin
      low = '0;
      case (sel_kind) // [RULE7]
         `ADDR_STATUS:
            low = {por_q, acc_q[`FLT_UV], acc_q[`FLT_OV],
                   acc_q[`FLT_OLON + out_i], acc_q[`FLT_OLOFF + out_i],
                   acc_q[`FLT_OS + out_i], acc_q[`FLT_OT + out_i],
                   acc_q[`FLT_SC + out_i], acc_q[`FLT_OC + out_i]}; // [RULE15]
         `ADDR_DUTY: low = {1'b0, rd_data[`DUTY_HI:0]}; // [RULE16]
         `ADDR_CONF0, `ADDR_CONF1, `ADDR_OCR: low = rd_data; // [RULE16]
         `ADDR_GCR:
            low = (out_i == `OUT_GLOBAL) ? gcr_q : '0;
         `ADDR_DIAG:
            case (out_i) // [RULE17]
               `OUT_GLOBAL: low = {6'h00, clock_fail, cal_fail,
                                   thermal_prewarning};
               `OUT_DIAG1:  low = {4'h0, in_s, watchdog_active};
               `OUT_DIAG2:  low = PRODUCT_IDENT;
               default:     low = '0;
            endcase
         default: low = '0;
      endcase
      tx_word = {wd_q, sel_q, normal_operation_flag, low}; // [RULE13] [RULE14]
   end

   assign readback_select_bits   = sel_q;
   assign watchdog_toggle_echo   = wd_q;
   assign global_config_register = gcr_q;

   //---------------------------------------------------------
   // checks
   //---------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_open;
      (state_q == LINK_IDLE) && cs_fall;
   endsequence
   sequence s_good_close;
      (state_q == LINK_FRAME) && cs_rise && len_ok;
   endsequence
   sequence s_bad_close;
      (state_q == LINK_FRAME) && cs_rise && !len_ok;
   endsequence
   sequence s_shift;
      (state_q == LINK_FRAME) && !cs_rise && sclk_fall;
   endsequence

   word_load_a: assert property ( // [RULE1]
      s_open |=> so_oe && so_out == $past(tx_word[`WORD_W-1]))
      else $error("loaded word msb missing on serial output");
   header_echo_a: assert property ( // [RULE13]
      s_open |=> shreg_q[`WORD_W-1:`OD_NM] ==
         {$past(wd_q), $past(sel_q), $past(normal_operation_flag)})
      else $error("header bits do not echo stored state");
   msb_shift_a: assert property ( // [RULE2]
      s_shift |=> so_out == $past(shreg_q[`WORD_W-2]))
      else $error("serial output did not advance msb first");
   echo_tail_a: assert property ( // [RULE4]
      s_shift ##0 (got_q && cnt_q == `CNT_ZERO) |=> shreg_q == $past(rx_q))
      else $error("tail bits do not echo received bits");
   select_take_a: assert property ( // [RULE9]
      s_good_close ##0 (cmd_addr == `ADDR_STATUS)
      |=> sel_q == $past(rx_q[`CMD_SEL_HI:`CMD_SEL_LO]) ##1 $stable(sel_q))
      else $error("select command not taken");
   bad_frame_a: assert property ( // [RULE11]
      s_bad_close |=> $stable(sel_q) && $stable(wd_q) && $stable(gcr_q)
                      && ($stable(por_q) || $past(por_event)) && !mem_wr)
      else $error("invalid frame changed state");
   wd_echo_a: assert property ( // [RULE12]
      s_good_close |=> wd_q == $past(rx_q[`CMD_WD]))
      else $error("watchdog echo not updated");
   float_end_a: assert property ( // [RULE6]
      (state_q == LINK_FRAME) && cs_rise |=> !so_oe)
      else $error("serial output still driven after frame");
   fault_freeze_a: assert property ( // [RULE10]
      (state_q == LINK_FRAME) && !cs_rise |=> $stable(acc_q))
      else $error("fault status moved inside a frame");
   por_read_a: assert property ( // [RULE18]
      s_good_close ##0 (load_fault_q && !por_event) |=> !por_q)
      else $error("power-on flag not cleared by its read");
   por_keep_a: assert property ( // [RULE18]
      por_q && !(cs_rise && len_ok && load_fault_q) |=> por_q)
      else $error("power-on flag cleared without a read");
   fault_word_a: assert property ( // [RULE15]
      s_open ##0 (sel_kind == `ADDR_STATUS)
      |=> shreg_q[`DATA_W-1] == $past(por_q))
      else $error("fault word lacks power-on flag");

endmodule : spi_status_readback

// File: src/spi_readback_defines.svh
// constants for the serial status readback block
//------------------------------------------------------------
// Notes on behaviour
// RULE1: select falling loads the selected status word
// RULE2: output shifts msb first while input shifts
// RULE3: first sixteen bits follow previous valid command
// RULE4: bits after sixteen echo received input bits
// RULE5: select rising accepts only multiples of sixteen
// RULE6: select rising floats output, reopens fault capture
// RULE7: five select bits choose the returned low field
// RULE8: upper two select bits choose the output
// RULE9: selection persists until next select command
// RULE10: status frozen at select fall, accumulated since
// RULE11: invalid frame leaves selection and status unchanged
// RULE12: bit fifteen echoes previous watchdog toggle bit
// RULE13: bits fourteen to ten echo select bits
// RULE14: bit nine high in normal operation
// RULE15: fault word holds the nine fault flags
// RULE16: configuration selections return programmed fields
// RULE17: diagnostic selections return flags, inputs, ident
// RULE18: power-on flag cleared only by reading it
// RULE19: host clocks whole words, selects before relying
//------------------------------------------------------------
`ifndef SPI_READBACK_DEFINES_SVH
`define SPI_READBACK_DEFINES_SVH

`define WORD_W      16
`define DATA_W      9
`define CNT_W       4
`define OUT_N       4
`define SEL_W       5
`define MEM_AW      4
`define MEM_DEPTH   16
`define SYNC_W      7
`define CNT_ZERO    4'h0
`define CNT_ONE     4'h1
`define SYNC_RESET  7'h02
`define EDGE_RESET  2'h2
`define POR_RESET   1'b1
// command and returned word fields
`define CMD_WD      15
`define CMD_OUT_HI  14
`define CMD_OUT_LO  13
`define CMD_ADDR_HI 12
`define CMD_ADDR_LO 10
`define CMD_SEL_HI  4
`define CMD_SEL_LO  0
`define OD_NM       9
`define DUTY_HI     7
// register kinds in the low select bits, outputs in the upper two
`define ADDR_STATUS 3'h0
`define ADDR_DUTY   3'h1
`define ADDR_CONF0  3'h2
`define ADDR_CONF1  3'h3
`define ADDR_OCR    3'h4
`define ADDR_GCR    3'h5
`define ADDR_DIAG   3'h7
`define OUT_GLOBAL  2'h0
`define OUT_DIAG1   2'h1
`define OUT_DIAG2   2'h2
// accumulated fault vector layout
`define FLT_W       26
`define FLT_OC      0
`define FLT_SC      4
`define FLT_OT      8
`define FLT_OS      12
`define FLT_OLOFF   16
`define FLT_OLON    20
`define FLT_OV      24
`define FLT_UV      25

`endif

// File: src/spi_readback_pkg.sv
// types shared by the serial status readback block
`include "spi_readback_defines.svh"

package spi_readback_pkg;
   typedef enum logic {LINK_IDLE, LINK_FRAME} link_state_t;
   typedef logic [`WORD_W-1:0] word_t;
   typedef logic [`DATA_W-1:0] field_t;
endpackage : spi_readback_pkg

// File: src/cfg_store.sv
// per-output configuration store with registered read data
`include "spi_readback_defines.svh"

module cfg_store
   import spi_readback_pkg::*;
(
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               reset_n,
   // write port
   input  wire logic               wr_en,
   input  wire logic [`MEM_AW-1:0] wr_addr,
   input  wire field_t             wr_data,
   // read port
   input  wire logic [`MEM_AW-1:0] rd_addr,
   output field_t                  rd_data
);

   field_t mem_q [`MEM_DEPTH];
   field_t mem_d [`MEM_DEPTH];
   field_t rd_d;

   // write decode and read select
   always_comb
   begin
      mem_d = mem_q;
      if (wr_en)
      begin
         mem_d[wr_addr] = wr_data;
      end
      rd_d = mem_q[rd_addr];
   end

   // storage and read register, all fields default to zero
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < `MEM_DEPTH; i++)
         begin
            mem_q[i] <= '0;
         end
         rd_data <= '0;
      end
      else
      begin
         mem_q   <= mem_d;
         rd_data <= rd_d;
      end
   end

endmodule : cfg_store

// File: verification/spi_host_model.sv
// host-side serial master model: mode 0, msb first, whole frames
module spi_host_model
(
   // clock
   input  wire logic ref_clk,
   // serial link pins
   output logic      sclk,
   output logic      cs_n,
   output logic      si,
   input  wire logic so_out,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   //--------------------------------------------------
   // idle levels
   //--------------------------------------------------
   // clock stands still low between frames, select inactive
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   //--------------------------------------------------
   // frame task
   //--------------------------------------------------
   // n bits, tx sent msb first; rx gathers so_out just before each rise
   task automatic xfer(input int n, input logic [31:0] tx,
                       output logic [31:0] rx, output logic oe_ok);
      rx    = '0;
      oe_ok = 1'b1;
      @(negedge ref_clk);
      cs_n = 1'b0;
      si   = tx[n-1];
      // loaded word needs a few cycles to reach so_out
      repeat (8) @(negedge ref_clk);
      // n is a multiple of 16 unless a refusal is wanted
      for (int i = n - 1; i >= 0; i--)
      begin
         rx[i] = so_out;
         oe_ok = oe_ok & so_oe;
         sclk  = 1'b1;
         repeat (4) @(negedge ref_clk);
         sclk  = 1'b0;
         // released data line shows the inverse of its last bit
         si    = (i > 0) ? tx[i-1] : ~tx[0];
         repeat (4) @(negedge ref_clk);
      end
      cs_n = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask : xfer
endmodule : spi_host_model

// File: verification/tb_top.sv
// self-checking bench for the serial status readback block
`include "spi_readback_defines.svh"

module tb_top
   import spi_readback_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // identification pattern, value arbitrary
   localparam field_t IDENT_VAL = 9'h1C6;

   logic              ref_clk   = 1'b0;
   logic              reset_n   = 1'b0;
   logic              sclk;
   logic              cs_n;
   logic              si;
   logic              so_out;
   logic              so_oe;
   logic [`OUT_N-1:0] oc_f, sc_f, ot_f, os_f, olf_f, oln_f, din;
   logic              uv_f, ov_f, por_f, nm, clk_f, cal_f, otw_f, wda;
   logic [`SEL_W-1:0] sel_o;
   logic              wd_o;
   field_t            gcr_o;
   int                n_fail    = 0;
   int                cmp_count = 0;
   logic              wd_p      = 1'b0;
   logic [4:0]        sel_p     = 5'h00;
   field_t            last;
   field_t            vals [4]  = '{9'h1A5, 9'h0C3, 9'h15A, 9'h1F0};
   field_t            lows [8];
   logic [15:0]       txs  [8];

   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;

   //--------------------------------------------------
   // instances
   //--------------------------------------------------
   spi_host_model spi_host_model_inst (
      .ref_clk (ref_clk),
      .sclk    (sclk),
      .cs_n    (cs_n),
      .si      (si),
      .so_out  (so_out),
      .so_oe   (so_oe)
   );

   spi_status_readback #(.PRODUCT_IDENT(IDENT_VAL))
      spi_status_readback_inst (
      .ref_clk                (ref_clk),
      .reset_n                (reset_n),
      .sclk                   (sclk),
      .cs_n                   (cs_n),
      .si                     (si),
      .so_out                 (so_out),
      .so_oe                  (so_oe),
      .overcurrent_flag       (oc_f),
      .severe_short_flag      (sc_f),
      .overtemperature_flag   (ot_f),
      .short_to_supply_flag   (os_f),
      .open_load_off_flag     (olf_f),
      .open_load_on_flag      (oln_f),
      .undervoltage_flag      (uv_f),
      .overvoltage_flag       (ov_f),
      .por_event              (por_f),
      .normal_operation_flag  (nm),
      .clock_fail             (clk_f),
      .cal_fail               (cal_f),
      .thermal_prewarning     (otw_f),
      .watchdog_active        (wda),
      .direct_in              (din),
      .readback_select_bits   (sel_o),
      .watchdog_toggle_echo   (wd_o),
      .global_config_register (gcr_o)
   );

   //--------------------------------------------------
   // helpers
   //--------------------------------------------------
   // command word: watchdog, output, kind, data
   function automatic logic [15:0] cmd(logic wd, logic [1:0] o,
                                       logic [2:0] k, field_t d);
      return {wd, o, k, 1'b0, d};
   endfunction : cmd

   // readback select command
   function automatic logic [15:0] sel_cmd(logic wd, logic [4:0] s);
      return {wd, 10'h000, s};
   endfunction : sel_cmd

   // compares one value and counts the result
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %0h expected %0h",
                  $time, got, exp);
      end
   endtask : check

   // one frame; checks the returned word, then tracks the stored state
   task automatic run(input int n, input logic [31:0] tx, input field_t low);
      logic [31:0] rx;
      logic        ok;
      logic [15:0] exp;
      exp = {wd_p, sel_p, nm, low};
      spi_host_model_inst.xfer(n, tx, rx, ok);
      if (n >= 16)
      begin
         check(32'(rx[n-1 -: 16]), 32'(exp));
         check(32'(ok), 32'h1);
      end
      if (n == 32)
         check(32'(rx[15:0]), 32'(tx[31:16]));
      check(32'(so_oe), 32'h0);
      if (n > 0 && n % 16 == 0)
      begin
         wd_p = tx[15];
         if (tx[12:10] == 3'h0)
            sel_p = tx[4:0];
      end
   endtask : run

   // prints the counts and the verdict, then ends the run
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   //--------------------------------------------------
   // main sequence
   //--------------------------------------------------
   initial
   begin
      {oc_f, sc_f, ot_f, os_f, olf_f, oln_f, din} = '0;
      {uv_f, ov_f, por_f, clk_f, cal_f, otw_f, wda} = '0;
      nm = 1'b1;
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (8) @(negedge ref_clk);
      // first frame shows the power-on flag of output 0
      run(16, sel_cmd(1'b0, 5'h08), 9'h100);
      // short fault pulses between frames are held for output 1
      {oc_f[1], ot_f[1], oln_f[1], uv_f, ov_f} = '1;
      @(negedge ref_clk);
      {oc_f[1], ot_f[1], oln_f[1], uv_f, ov_f} = '0;
      run(16, sel_cmd(1'b1, 5'h08), 9'h0E5);
      run(16, sel_cmd(1'b0, 5'h08), 9'h000);
      // short frame is refused; faults keep accumulating through it
      {os_f[1], olf_f[1], sc_f[1], oc_f[0]} = '1;
      @(negedge ref_clk);
      {os_f[1], olf_f[1], sc_f[1], oc_f[0]} = '0;
      run(8, 32'h0000_00FF, 9'h000);
      run(16, sel_cmd(1'b0, 5'h08), 9'h01A);
      // per-output words: select, write output 3, write output 0
      last = 9'h000;
      for (int k = 1; k <= 4; k++)
      begin
         run(16, sel_cmd(k[0], {2'h3, k[2:0]}), last);
         run(16, cmd(1'b0, 2'h3, k[2:0], vals[k-1]), 9'h000);
         last = (k == 1) ? {1'b0, vals[k-1][7:0]} : vals[k-1];
         run(16, cmd(1'b1, 2'h0, k[2:0], ~vals[k-1]), last);
      end
      // global word, diagnostics, power-on flag kept until read
      {clk_f, cal_f, otw_f, wda} = 4'hB;
      din   = 4'hA;
      por_f = 1'b1;
      @(negedge ref_clk);
      por_f = 1'b0;
      txs  = '{sel_cmd(1'b0, 5'h04), cmd(1'b1, 2'h0, 3'h5, 9'h155),
               sel_cmd(1'b0, 5'h05), sel_cmd(1'b1, 5'h07),
               sel_cmd(1'b0, 5'h0F), sel_cmd(1'b1, 5'h17),
               sel_cmd(1'b0, 5'h08), sel_cmd(1'b1, 5'h08)};
      lows = '{last, ~vals[3], ~vals[3], 9'h155, 9'h005, 9'h015,
               IDENT_VAL, 9'h100};
      for (int i = 0; i < 8; i++)
         run(16, {16'h0000, txs[i]}, lows[i]);
      check(32'(gcr_o), 32'h155);
      // global word asked for another output reads as zero
      run(16, sel_cmd(1'b1, 5'h0D), 9'h000);
      // chained frame in fail-safe mode; last word is the command
      nm = 1'b0;
      run(32, {sel_cmd(1'b1, 5'h08), sel_cmd(1'b0, 5'h08)}, 9'h0);
      check(32'(sel_o), 32'(sel_p));
      check(32'(wd_o), 32'(wd_p));
      complete_run();
   end

   // cuts a hang short
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      n_fail++;
      complete_run();
   end
endmodule : tb_top
